// ==== rtl/pid_top.sv ====
`timescale 1ns/1ns
`include "pid_regs.svh"
// Function
// - two-bit select field picks which of four ports feeds the channels
// - control bit 7 sets level or edge type for channels 6 and 7
// - control bit 6 sets level or edge type for channels 4 and 5
// - control bits 2 to 5 set type of channels 0 to 3
// - negative enable per channel arms low level or falling edge detection
// - positive enable per channel arms high level or rising edge detection
// - channel type bit decides whether enables act on levels or edges
// - edge mode: enabled edge sets the flag, which holds until cleared
// - level mode: flag shows inverted pin level, writes ignored
// - both polarity enable registers reset to zero
// - low priority bit 1 in extended priority register, paired with high register
module pid_top
	import pid_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// register bus
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// port pins
	input  wire logic [7:0]  port0_pins,
	input  wire logic [7:0]  port1_pins,
	input  wire logic [7:0]  port2_pins,
	input  wire logic [7:0]  port3_pins,
	// toward the core
	output logic             pin_irq,
	output logic             pin_irq_priority_low,
	output logic             pin_irq_priority_high
);

	// ************************************************************
	// state
	// ************************************************************

	pid_state_type s_q;
	pid_state_type s_d;
	pid_reg_type   reg_sel;
	logic          rd_stb;
	logic          wr_stb;
	logic [7:0]    port_mux;
	logic [7:0]    edge_mode;
	logic [7:0]    flag_d;
	logic [7:0]    flag_rd;
	logic [7:0]    hit;
	logic [7:0]    flag_clr;
	logic [7:0]    wbyte;

	// ************************************************************
	// type decoding
	// ************************************************************

	function automatic logic type_bit(input logic [7:0] ctrl, input int ch);
		if (ch >= 6) begin
			type_bit = ctrl[`PID_CTRL_T67_BIT];
		end else if (ch >= 4) begin
			type_bit = ctrl[`PID_CTRL_T45_BIT];
		end else begin
			type_bit = ctrl[`PID_CTRL_T0_BIT + ch];
		end
	endfunction : type_bit

	always_comb begin
		case (s_q.ctrl[`PID_CTRL_SEL_MSB:`PID_CTRL_SEL_LSB])
			2'h0:    port_mux = port0_pins;
			2'h1:    port_mux = port1_pins;
			2'h2:    port_mux = port2_pins;
			2'h3:    port_mux = port3_pins;
			default: port_mux = port0_pins;
		endcase
	end

	// ************************************************************
	// bus slave
	// ************************************************************

	pid_avmm u_bus (
		.clk_sys         (clk_sys),
		.sys_rst         (sys_rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_byteenable  (avs_byteenable),
		.avs_waitrequest (avs_waitrequest),
		.reg_sel         (reg_sel),
		.rd_stb          (rd_stb),
		.wr_stb          (wr_stb)
	);

	assign wbyte    = avs_writedata[7:0];
	// a zero written to an edge flag clears it, a one leaves it
	assign flag_clr = (wr_stb && reg_sel == PID_REG_FLAGS) ? ~wbyte : 8'h00;

	// ************************************************************
	// channels
	// ************************************************************

	for (genvar i = 0; i < 8; i++) begin : g_chan
		assign edge_mode[i] = type_bit(s_q.ctrl, i);

		pid_chan u_chan (
			.pin_now   (s_q.pin_now[i]),
			.pin_prev  (s_q.pin_prev[i]),
			.primed    (s_q.primed),
			.edge_mode (edge_mode[i]),
			.neg_en    (s_q.neg_en[i]),
			.pos_en    (s_q.pos_en[i]),
			.flag_q    (s_q.edge_flags[i]),
			.clr       (flag_clr[i]),
			.flag_d    (flag_d[i]),
			.flag_rd   (flag_rd[i]),
			.hit       (hit[i])
		);
	end

	// ************************************************************
	// next state
	// ************************************************************

	always_comb begin
		s_d            = s_q;
		s_d.pin_now    = port_mux;
		// first sample stands in as its own predecessor, so reset shows no false edge
		s_d.pin_prev   = s_q.primed ? s_q.pin_now : port_mux;
		s_d.primed     = 1'b1;
		s_d.edge_flags = flag_d;
		if (wr_stb) begin
			case (reg_sel)
				PID_REG_CTRL:    s_d.ctrl    = wbyte;
				PID_REG_NEG:     s_d.neg_en  = wbyte;
				PID_REG_POS:     s_d.pos_en  = wbyte;
				PID_REG_PRIO_LO: s_d.prio_lo = wbyte[`PID_PRIO_BIT];
				PID_REG_PRIO_HI: s_d.prio_hi = wbyte[`PID_PRIO_BIT];
				default:         s_d.ctrl    = s_q.ctrl;
			endcase
		end
		if (rd_stb) begin
			case (reg_sel)
				PID_REG_CTRL:    s_d.rdata = s_q.ctrl;
				PID_REG_NEG:     s_d.rdata = s_q.neg_en;
				PID_REG_POS:     s_d.rdata = s_q.pos_en;
				PID_REG_FLAGS:   s_d.rdata = flag_rd;
				PID_REG_PRIO_LO: s_d.rdata = {6'h00, s_q.prio_lo, 1'h0};
				PID_REG_PRIO_HI: s_d.rdata = {6'h00, s_q.prio_hi, 1'h0};
				default:         s_d.rdata = `PID_BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q.ctrl       <= `PID_CTRL_RST;
			s_q.neg_en     <= `PID_NEG_EN_RST;
			s_q.pos_en     <= `PID_POS_EN_RST;
			s_q.edge_flags <= `PID_BYTE_ZERO;
			s_q.prio_lo    <= 1'b0;
			s_q.prio_hi    <= 1'b0;
			s_q.pin_now    <= `PID_BYTE_ZERO;
			s_q.pin_prev   <= `PID_BYTE_ZERO;
			s_q.primed     <= 1'b0;
			s_q.rdata      <= `PID_BYTE_ZERO;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************

	assign avs_readdata          = {24'h000000, s_q.rdata};
	assign pin_irq               = |hit;
	assign pin_irq_priority_low  = s_q.prio_lo;
	assign pin_irq_priority_high = s_q.prio_hi;

	// ************************************************************
	// checks
	// ************************************************************

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	port_select_a:
	assert property ($past(s_q.ctrl[1:0]) == 2'h2 && !$past(sys_rst) |-> s_q.pin_now == $past(port2_pins))
		else $error("selected port not sampled");

	type_upper_a:
	assert property (edge_mode[7] == s_q.ctrl[7] && edge_mode[6] == s_q.ctrl[7] && edge_mode[4] == s_q.ctrl[6])
		else $error("shared type bit not applied");

	edge_flag_set_a:
	assert property (edge_mode[0] && s_q.neg_en[0] && s_q.primed && s_q.pin_prev[0] && !s_q.pin_now[0]
		|=> !edge_mode[0] || (flag_rd[0] && pin_irq))
		else $error("falling edge did not set flag");

	edge_flag_hold_a:
	assert property (edge_mode[3] && s_q.edge_flags[3] && !flag_clr[3] && $stable(s_q.ctrl) [*1]
		|=> s_q.edge_flags[3] || !edge_mode[3])
		else $error("edge flag lost without clear");

	flag_clear_a:
	assert property (edge_mode[2] && flag_clr[2] && s_q.pin_prev[2] == s_q.pin_now[2] |=> !s_q.edge_flags[2])
		else $error("edge flag not cleared by write");

	level_flag_a:
	assert property ((flag_rd & ~edge_mode) == (~s_q.pin_now & ~edge_mode))
		else $error("level flag not inverse of pin");

	enable_reset_a:
	assert property (disable iff (1'b0) $past(sys_rst) && !sys_rst |-> s_q.neg_en == 8'h00 && s_q.pos_en == 8'h00)
		else $error("polarity enables not zero after reset");

	prio_write_a:
	assert property (wr_stb && reg_sel == PID_REG_PRIO_LO |=> pin_irq_priority_low == $past(avs_writedata[1]))
		else $error("priority low bit not written");

	level_irq_a:
	assert property (!edge_mode[5] && s_q.pos_en[5] && s_q.pin_now[5] |-> pin_irq)
		else $error("enabled high level gave no request");

	bus_answer_a:
	assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("bus request not answered in time");

	// ************************************************************
	// checks on registers and sampling
	// ************************************************************

	port_zero_a:
	assert property ($past(s_q.ctrl[1:0]) == 2'h0 && !$past(sys_rst)
		|-> s_q.pin_now == $past(port0_pins))
		else $error("port 0 not sampled when selected");

	port_one_a:
	assert property ($past(s_q.ctrl[1:0]) == 2'h1 && !$past(sys_rst)
		|-> s_q.pin_now == $past(port1_pins))
		else $error("port 1 not sampled when selected");

	port_three_a:
	assert property ($past(s_q.ctrl[1:0]) == 2'h3 && !$past(sys_rst)
		|-> s_q.pin_now == $past(port3_pins))
		else $error("port 3 not sampled when selected");

	type_lower_a:
	assert property (edge_mode[3:0] == s_q.ctrl[5:2])
		else $error("own type bits not applied");

	type_pair_a:
	assert property (edge_mode[5] == s_q.ctrl[6])
		else $error("pair type bit not applied to channel 5");

	level_no_store_a:
	assert property (!$past(sys_rst)
		|-> (s_q.edge_flags & ~$past(edge_mode)) == 8'h00)
		else $error("level channel kept a stored flag");

	rise_flag_set_a:
	assert property (edge_mode[1] && s_q.pos_en[1] && s_q.primed && !s_q.pin_prev[1] && s_q.pin_now[1]
		|=> s_q.edge_flags[1])
		else $error("rising edge did not set flag");

	rise_ignored_a:
	assert property (edge_mode[4] && !s_q.pos_en[4] && !s_q.edge_flags[4] && s_q.pin_now[4]
		|=> !s_q.edge_flags[4])
		else $error("disabled rising edge set flag");

	level_low_irq_a:
	assert property (!edge_mode[0] && s_q.neg_en[0] && !s_q.pin_now[0]
		|-> pin_irq)
		else $error("enabled low level gave no request");

	level_idle_a:
	assert property (!edge_mode[7] && !s_q.neg_en[7] && !s_q.pos_en[7]
		|-> !hit[7])
		else $error("level channel without enables reported event");

	irq_quiet_a:
	assert property (s_q.neg_en == 8'h00 && s_q.pos_en == 8'h00 && s_q.edge_flags == 8'h00
		|-> !pin_irq)
		else $error("request raised with nothing enabled");

	edge_irq_a:
	assert property ((s_q.edge_flags & edge_mode) != 8'h00
		|-> pin_irq)
		else $error("edge flag set but no request");

	edge_read_a:
	assert property (edge_mode[6]
		|-> flag_rd[6] == s_q.edge_flags[6])
		else $error("edge flag not shown on read");

	flag_keep_a:
	assert property (edge_mode[0] && s_q.edge_flags[0] && wr_stb && reg_sel == PID_REG_FLAGS && wbyte[0]
		|=> s_q.edge_flags[0])
		else $error("writing one dropped an edge flag");

	no_second_set_a:
	assert property (edge_mode[0] && flag_clr[0] && s_q.pin_prev[0] == s_q.pin_now[0]
		|=> !s_q.edge_flags[0])
		else $error("steady pin set the flag again");

	sample_chain_a:
	assert property (s_q.primed
		|=> s_q.pin_prev == $past(s_q.pin_now))
		else $error("previous sample not kept");

	first_sample_a:
	assert property (!s_q.primed
		|=> s_q.pin_prev == s_q.pin_now)
		else $error("first sample gave a false edge");

	ctrl_write_a:
	assert property (wr_stb && reg_sel == PID_REG_CTRL
		|=> s_q.ctrl == $past(wbyte))
		else $error("control write not stored");

	neg_write_a:
	assert property (wr_stb && reg_sel == PID_REG_NEG
		|=> s_q.neg_en == $past(wbyte))
		else $error("negative enable write not stored");

	pos_write_a:
	assert property (wr_stb && reg_sel == PID_REG_POS
		|=> s_q.pos_en == $past(wbyte))
		else $error("positive enable write not stored");

	prio_high_a:
	assert property (wr_stb && reg_sel == PID_REG_PRIO_HI
		|=> pin_irq_priority_high == $past(avs_writedata[1]))
		else $error("priority high bit not written");

	read_wait_a:
	assert property (rd_stb
		|-> avs_waitrequest)
		else $error("read capture outside wait cycle");

	write_late_a:
	assert property (wr_stb
		|-> !avs_waitrequest)
		else $error("write landed while waiting");

	read_capture_a:
	assert property (rd_stb && reg_sel == PID_REG_NEG
		|=> avs_readdata == {24'h000000, $past(s_q.neg_en)})
		else $error("read data not captured");

endmodule : pid_top

// ==== rtl/pid_regs.svh ====
`ifndef PID_REGS_SVH
`define PID_REGS_SVH

// register indices; byte address is four times the index
`define PID_CTRL_IDX      8'hE9
`define PID_NEG_EN_IDX    8'hEA
`define PID_POS_EN_IDX    8'hEB
`define PID_FLAGS_IDX     8'hEC
`define PID_PRIO_LO_IDX   8'hEF
`define PID_PRIO_HI_IDX   8'hF7

// control register fields
`define PID_CTRL_SEL_LSB  0
`define PID_CTRL_SEL_MSB  1
`define PID_CTRL_T0_BIT   2
`define PID_CTRL_T45_BIT  6
`define PID_CTRL_T67_BIT  7

// priority bit of this source in both priority registers
`define PID_PRIO_BIT      1

// reset values
`define PID_CTRL_RST      8'h00
`define PID_NEG_EN_RST    8'h00
`define PID_POS_EN_RST    8'h00
`define PID_BYTE_ZERO     8'h00

`endif

// ==== rtl/pid_pkg.sv ====
package pid_pkg;

	typedef enum logic [2:0] {
		PID_REG_NONE    = 3'h0,
		PID_REG_CTRL    = 3'h1,
		PID_REG_NEG     = 3'h2,
		PID_REG_POS     = 3'h3,
		PID_REG_FLAGS   = 3'h4,
		PID_REG_PRIO_LO = 3'h5,
		PID_REG_PRIO_HI = 3'h6
	} pid_reg_type;

	typedef enum logic [1:0] {
		PID_BUS_IDLE = 2'h0,
		PID_BUS_ACK  = 2'h1
	} pid_bus_state_type;

	typedef struct packed {
		pid_bus_state_type state;
	} pid_bus_type;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] neg_en;
		logic [7:0] pos_en;
		logic [7:0] edge_flags;
		logic       prio_lo;
		logic       prio_hi;
		logic [7:0] pin_now;
		logic [7:0] pin_prev;
		logic       primed;
		logic [7:0] rdata;
	} pid_state_type;

endpackage : pid_pkg

// ==== rtl/pid_chan.sv ====
`timescale 1ns/1ns
module pid_chan
	import pid_pkg::*;
(
	// sampled pin
	input  wire logic pin_now,
	input  wire logic pin_prev,
	input  wire logic primed,
	// configuration
	input  wire logic edge_mode,
	input  wire logic neg_en,
	input  wire logic pos_en,
	// flag state and software clear
	input  wire logic flag_q,
	input  wire logic clr,
	// results
	output logic      flag_d,
	output logic      flag_rd,
	output logic      hit
);

	logic fall;
	logic rise;
	logic edge_hit;

	// one edge per pair of samples, so each edge sets the flag once
	assign fall     = primed & pin_prev & ~pin_now;
	assign rise     = primed & ~pin_prev & pin_now;
	assign edge_hit = (neg_en & fall) | (pos_en & rise);

	always_comb begin
		if (!edge_mode) begin
			flag_d = 1'b0;
		end else if (edge_hit) begin
			// a new edge beats a clear in the same cycle
			flag_d = 1'b1;
		end else if (clr) begin
			flag_d = 1'b0;
		end else begin
			flag_d = flag_q;
		end
	end

	// level mode: flag mirrors inverted pin, writes have no effect
	assign flag_rd = edge_mode ? flag_q : ~pin_now;
	assign hit     = edge_mode ? flag_q : ((neg_en & ~pin_now) | (pos_en & pin_now));

endmodule : pid_chan

// ==== rtl/pid_avmm.sv ====
`timescale 1ns/1ns
`include "pid_regs.svh"
module pid_avmm
	import pid_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// avalon request
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	output logic             avs_waitrequest,
	// strobes to the register file
	output pid_reg_type      reg_sel,
	output logic             rd_stb,
	output logic             wr_stb
);

	pid_bus_type s_q;
	pid_bus_type s_d;

	function automatic pid_reg_type decode(input logic [7:0] idx);
		case (idx)
			`PID_CTRL_IDX:    decode = PID_REG_CTRL;
			`PID_NEG_EN_IDX:  decode = PID_REG_NEG;
			`PID_POS_EN_IDX:  decode = PID_REG_POS;
			`PID_FLAGS_IDX:   decode = PID_REG_FLAGS;
			`PID_PRIO_LO_IDX: decode = PID_REG_PRIO_LO;
			`PID_PRIO_HI_IDX: decode = PID_REG_PRIO_HI;
			default:          decode = PID_REG_NONE;
		endcase
	endfunction : decode

	// one wait cycle: read data are captured first, writes land on release
	always_comb begin
		s_d = s_q;
		case (s_q.state)
			PID_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					s_d.state = PID_BUS_ACK;
				end
			end
			PID_BUS_ACK: begin
				s_d.state = PID_BUS_IDLE;
			end
			default: begin
				s_d.state = PID_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q.state <= PID_BUS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_sel         = decode(avs_address[9:2]);
	assign avs_waitrequest = (avs_read | avs_write) & (s_q.state != PID_BUS_ACK);
	assign rd_stb          = avs_read & (s_q.state == PID_BUS_IDLE);
	// data live in byte lane 0 only
	assign wr_stb          = avs_write & (s_q.state == PID_BUS_ACK) & avs_byteenable[0];

endmodule : pid_avmm

// ==== verif/pid_pins_model.sv ====
`timescale 1ns/1ns
module pid_pins_model (
	// clock and stimulus
	input  wire logic       clk_sys,
	input  wire logic [1:0] sel,
	input  wire logic [7:0] lvl,
	// port pins
	output logic      [7:0] port0_pins,
	output logic      [7:0] port1_pins,
	output logic      [7:0] port2_pins,
	output logic      [7:0] port3_pins
);
	// ****
	// pins
	// ****
	// idle ports toggle bits 2 to 7 every cycle so a wrong port select shows up as events
	logic [7:0] noise_q = 8'h5A;
	always @(posedge clk_sys) begin
		noise_q <= ~noise_q + 8'h01;
	end
	assign port0_pins = (sel == 2'h0) ? lvl : noise_q;
	assign port1_pins = (sel == 2'h1) ? lvl : noise_q;
	assign port2_pins = (sel == 2'h2) ? lvl : noise_q;
	assign port3_pins = (sel == 2'h3) ? lvl : noise_q;
endmodule : pid_pins_model

// ==== verif/pid_top_tb_top.sv ====
`timescale 1ns/1ns
`include "pid_regs.svh"
module pid_top_tb_top;
	// ****
	// signals
	// ****
	localparam logic [9:0] A_CTL = {`PID_CTRL_IDX, 2'h0};
	localparam logic [9:0] A_NEG = {`PID_NEG_EN_IDX, 2'h0};
	localparam logic [9:0] A_POS = {`PID_POS_EN_IDX, 2'h0};
	localparam logic [9:0] A_FLG = {`PID_FLAGS_IDX, 2'h0};
	localparam logic [9:0] A_PLO = {`PID_PRIO_LO_IDX, 2'h0};
	localparam logic [9:0] A_PHI = {`PID_PRIO_HI_IDX, 2'h0};
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic [9:0]  avs_address = 10'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  p0, p1, p2, p3;
	logic [1:0]  sel = 2'h0;
	logic [7:0]  lvl = 8'h00;
	logic        irq, plo, phi;
	logic [31:0] expq[$];
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [7:0]  v;
	logic [7:0]  masks [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h30, 8'hC0};

	always #2 clk_sys = ~clk_sys;

	pid_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port0_pins(p0), .port1_pins(p1),
		.port2_pins(p2), .port3_pins(p3), .pin_irq(irq), .pin_irq_priority_low(plo),
		.pin_irq_priority_high(phi));
	pid_pins_model pins_u (.clk_sys(clk_sys), .sel(sel), .lvl(lvl), .port0_pins(p0), .port1_pins(p1),
		.port2_pins(p2), .port3_pins(p3));

	// ****
	// tasks
	// ****
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	task complete_run;
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// request held until waitrequest is sampled low, then released a cycle
	task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk_sys iff !avs_waitrequest);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask : acc

	task wr(input logic [9:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask : wr

	task rd(input logic [9:0] a, input logic [7:0] e);
		expq.push_back({24'h0, e});
		acc(1'b0, a, 8'h00);
	endtask : rd

	task settle;
		repeat (3) @(posedge clk_sys);
	endtask : settle

	// ****
	// monitor and timeout
	// ****
	always @(posedge clk_sys) begin
		cyc++;
		if (avs_read && !avs_waitrequest && expq.size() > 0)
			cmp("readdata", expq.pop_front(), avs_readdata);
		if (cyc > 5000) begin
			n_errors++;
			complete_run();
		end
	end

	// ****
	// sequence
	// ****
	initial begin
		void'($urandom(48493));
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd(A_NEG, 8'h00);
		rd(A_POS, 8'h00);
		rd(A_FLG + 10'h004, 8'h00);
		for (int s = 0; s < 4; s++) begin
			v = 8'($urandom);
			sel <= 2'(s);
			wr(A_CTL, {6'h00, 2'(s)});
			lvl <= v;
			settle();
			rd(A_FLG, ~v);
			wr(A_FLG, 8'h00);
			rd(A_FLG, ~v);
		end
		sel <= 2'h0;
		wr(A_CTL, 8'h00);
		lvl <= 8'h00;
		wr(A_POS, 8'hFF);
		for (int i = 2; i < 8; i++) begin
			wr(A_CTL, 8'h00);
			settle();
			wr(A_CTL, 8'h01 << i);
			lvl <= 8'hFF;
			settle();
			rd(A_FLG, masks[i-2]);
			lvl <= 8'h00;
		end
		cmp("pin_irq", 1'b1, irq);
		wr(A_CTL, 8'h00);
		wr(A_POS, 8'h00);
		wr(A_NEG, 8'hFF);
		lvl <= 8'hFF;
		wr(A_CTL, 8'hFC);
		settle();
		lvl <= 8'h00;
		settle();
		rd(A_FLG, 8'hFF);
		lvl <= 8'hFF;
		settle();
		rd(A_FLG, 8'hFF);
		wr(A_FLG, 8'h0F);
		rd(A_FLG, 8'h0F);
		wr(A_FLG, 8'h00);
		rd(A_FLG, 8'h00);
		cmp("pin_irq", 1'b0, irq);
		wr(A_PLO, 8'hFF);
		wr(A_PHI, 8'h02);
		rd(A_PLO, 8'h02);
		rd(A_PHI, 8'h02);
		cmp("priority_low", 1'b1, plo);
		cmp("priority_high", 1'b1, phi);
		complete_run();
	end
endmodule : pid_top_tb_top
